// ==== rtl/lucc_chan_decode.sv ====
// Decodes one channel's command registers into control fields.
// Assumes register words come from flip-flops in the register bank.
`timescale 1ns/1ps
module lucc_chan_decode
    import lucc_pkg::*;
(
    input  wire logic [lucc_pkg::REG_W-1:0] i_tx_ctrl,
    input  wire logic [lucc_pkg::REG_W-1:0] i_rx_det,
    input  wire logic [lucc_pkg::REG_W-1:0] i_rx_out,
    input  wire logic [lucc_pkg::REG_W-1:0] i_rate_loop,
    output lucc_pkg::lucc_ctrl_type         o_ctrl
);
    import lucc_pkg::*;

    lucc_rate_type rate;
    lucc_loop_type loop;

    // Rate: the E3 bit wins, and the STS-1 bit is ignored while it is set.
    always_comb
    begin
        if (i_rate_loop[BIT_E3])
            rate = LUCC_RATE_E3;
        else if (i_rate_loop[BIT_STS1])
            rate = LUCC_RATE_STS1;
        else
            rate = LUCC_RATE_DS3;
    end

    // Loopback from the local and remote pair.
    always_comb
    begin
        case ({i_rate_loop[BIT_LLB], i_rate_loop[BIT_RLB]})
            2'b10:   loop = LUCC_LOOP_ANALOG;
            2'b11:   loop = LUCC_LOOP_DIGITAL;
            2'b01:   loop = LUCC_LOOP_REMOTE;
            default: loop = LUCC_LOOP_NONE;
        endcase
    end

    // Field decode; the build-out bypass only counts outside E3.
    always_comb
    begin
        o_ctrl.transmitter_disable = i_tx_ctrl[BIT_TX_DISABLE];
        o_ctrl.send_all_ones       = i_tx_ctrl[BIT_ALL_ONES];
        o_ctrl.tx_sample_rising    = i_tx_ctrl[BIT_TX_EDGE];
        o_ctrl.build_out_bypass    = i_tx_ctrl[BIT_BUILD_BYPASS]
                                     && (rate != LUCC_RATE_E3);
        o_ctrl.analog_detector_on  = !i_rx_det[BIT_ALOS_OFF];
        o_ctrl.digital_detector_on = !i_rx_det[BIT_DLOS_OFF];
        o_ctrl.equalizer_on        = i_rx_det[BIT_EQ_ON];
        o_ctrl.coder_enable        = i_rx_out[BIT_RAIL_FMT];
        o_ctrl.coder_hdb3          = (rate == LUCC_RATE_E3);
        o_ctrl.mute_on_signal_loss = i_rx_out[BIT_MUTE];
        o_ctrl.receiver_shutdown   = i_rx_out[BIT_RX_SHUTDOWN];
        o_ctrl.rx_output_falling   = i_rx_out[BIT_RX_EDGE];
        o_ctrl.rate                = rate;
        o_ctrl.loop                = loop;
    end

endmodule : lucc_chan_decode

// ==== rtl/lucc_pkg.sv ====
// Package for the per-channel line unit command register bank.
// Assumes one synchronous clock domain and 5-bit command registers.
package lucc_pkg;

    // Register geometry.
    localparam int unsigned REG_W       = 5;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned NUM_CH      = 3;
    localparam int unsigned REGS_PER_CH = 8;

    // Register indices within one channel's block of eight.
    localparam logic [2:0] IDX_ALARM_STATUS   = 3'h0;
    localparam logic [2:0] IDX_TX_CONTROL     = 3'h1;
    localparam logic [2:0] IDX_RX_DETECT_CTRL = 3'h2;
    localparam logic [2:0] IDX_RX_OUTPUT_CTRL = 3'h3;
    localparam logic [2:0] IDX_RATE_LOOP_SEL  = 3'h4;

    // Bit positions, status register.
    localparam int unsigned BIT_COMBINED_LOSS = 3;
    localparam int unsigned BIT_ANALOG_LOSS   = 2;
    localparam int unsigned BIT_DIGITAL_LOSS  = 1;
    localparam int unsigned BIT_DRIVE_MON     = 0;
    // Bit positions, transmit control.
    localparam int unsigned BIT_TX_DISABLE    = 4;
    localparam int unsigned BIT_ALL_ONES      = 3;
    localparam int unsigned BIT_TX_EDGE       = 2;
    localparam int unsigned BIT_BUILD_BYPASS  = 1;
    // Bit positions, receive detect control.
    localparam int unsigned BIT_ALOS_OFF      = 2;
    localparam int unsigned BIT_DLOS_OFF      = 1;
    localparam int unsigned BIT_EQ_ON         = 0;
    // Bit positions, receive output control.
    localparam int unsigned BIT_RAIL_FMT      = 4;
    localparam int unsigned BIT_MUTE          = 3;
    localparam int unsigned BIT_RX_SHUTDOWN   = 2;
    localparam int unsigned BIT_RX_EDGE       = 1;
    // Bit positions, rate and loopback select.
    localparam int unsigned BIT_STS1          = 3;
    localparam int unsigned BIT_E3            = 2;
    localparam int unsigned BIT_LLB           = 1;
    localparam int unsigned BIT_RLB           = 0;

    // Writable-bit masks; reserved positions are held at zero, except transmit control bit 0, which is writable.
    localparam logic [REG_W-1:0] MASK_TX_CONTROL     = 5'h1F;
    localparam logic [REG_W-1:0] MASK_RX_DETECT_CTRL = 5'h07;
    localparam logic [REG_W-1:0] MASK_RX_OUTPUT_CTRL = 5'h1E;
    localparam logic [REG_W-1:0] MASK_RATE_LOOP_SEL  = 5'h0F;

    // Reset value of every command register.
    localparam logic [REG_W-1:0] REG_RESET = 5'h00;

    // Line rate and loopback modes.
    typedef enum logic [1:0] {
        LUCC_RATE_DS3,
        LUCC_RATE_STS1,
        LUCC_RATE_E3
    } lucc_rate_type;

    typedef enum logic [1:0] {
        LUCC_LOOP_NONE,
        LUCC_LOOP_ANALOG,
        LUCC_LOOP_DIGITAL,
        LUCC_LOOP_REMOTE
    } lucc_loop_type;

    // Live detector and pin state of one channel.
    typedef struct packed {
        logic analog_loss;
        logic digital_loss;
        logic drive_monitor;
    } lucc_status_type;

    // Decoded controls of one channel.
    typedef struct packed {
        logic          transmitter_disable;
        logic          send_all_ones;
        logic          tx_sample_rising;
        logic          build_out_bypass;
        logic          analog_detector_on;
        logic          digital_detector_on;
        logic          equalizer_on;
        logic          coder_enable;
        logic          coder_hdb3;
        logic          mute_on_signal_loss;
        logic          receiver_shutdown;
        logic          rx_output_falling;
        lucc_rate_type rate;
        lucc_loop_type loop;
    } lucc_ctrl_type;

    // Register write/read request from the serial port engine.
    typedef struct packed {
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } lucc_req_type;

endpackage : lucc_pkg

// ==== rtl/lucc_regs.sv ====
// Command register bank for a three-channel line interface unit.
// Assumes the serial port engine delivers decoded register requests
// synchronous to i_clk_sys, and detector levels synchronous as well.
`timescale 1ns/1ps

// Summary of operation
// - Analog loss bit shows analog detector live
// - Digital loss bit shows digital detector live
// - Drive monitor bit shows monitor pin level
// - Transmitter off bit tri-states line output
// - All-ones bit replaces data with ones
// - Transmit edge bit: 1 rising, 0 falling
// - Build-out bypass bit disables build-out circuit
// - Build-out bypass ignored in E3 mode
// - Analog detector disable leaves digital only
// - Digital detector disable leaves analog only
// - Equalizer enable bit switches receive equalizer
// - Rail bit enables coders, single-rail output
// - Coder uses HDB3 in E3, else B3ZS
// - Mute bit zeroes receive data during loss
// - Receiver off bit shuts receive sections
// - Receive edge bit: 0 rising, 1 falling
// - Reserved bits have no function
// - E3 bit overrides STS-1/DS3 select
// - Loopback pair selects none/analog/digital/remote
module lucc_regs
    import lucc_pkg::*;
#(
    parameter int unsigned CHANNELS = lucc_pkg::NUM_CH
)
(
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_nrst,
    input  lucc_pkg::lucc_req_type              i_req,
    output logic [lucc_pkg::REG_W-1:0]          o_rdata,
    input  lucc_pkg::lucc_status_type [CHANNELS-1:0] i_status,
    input  wire logic [CHANNELS-1:0]            i_rx_pos,
    input  wire logic [CHANNELS-1:0]            i_rx_neg,
    input  wire logic [CHANNELS-1:0]            i_tx_positive_data_in,
    output lucc_pkg::lucc_ctrl_type [CHANNELS-1:0] o_ctrl,
    output logic [CHANNELS-1:0]                 o_combined_loss,
    output logic [CHANNELS-1:0]                 o_rx_positive_data_out,
    output logic [CHANNELS-1:0]                 o_rx_negative_data_out,
    output logic [CHANNELS-1:0]                 o_tx_line_data,
    output logic [CHANNELS-1:0]                 o_tx_line_oe
);
    import lucc_pkg::*;

    localparam int unsigned TOTAL = CHANNELS * REGS_PER_CH;

    // Storage: one word per writable register per channel; only writable registers are kept.
    logic [REG_W-1:0] tx_r        [CHANNELS];
    logic [REG_W-1:0] tx_nxt      [CHANNELS];
    logic [REG_W-1:0] det_r       [CHANNELS];
    logic [REG_W-1:0] det_nxt     [CHANNELS];
    logic [REG_W-1:0] out_r       [CHANNELS];
    logic [REG_W-1:0] out_nxt     [CHANNELS];
    logic [REG_W-1:0] rl_r        [CHANNELS];
    logic [REG_W-1:0] rl_nxt      [CHANNELS];
    logic [REG_W-1:0] rdata_r;
    logic [REG_W-1:0] rdata_nxt;

    // Splits an address into channel number and register index.
    function automatic logic [1:0] addr_chan(input logic [ADDR_W-1:0] a);
        addr_chan = a[ADDR_W-1:3];
    endfunction : addr_chan

    function automatic logic [2:0] addr_idx(input logic [ADDR_W-1:0] a);
        addr_idx = a[2:0];
    endfunction : addr_idx

    // Builds the live status word of one channel.
    function automatic logic [REG_W-1:0] status_word(
        input lucc_status_type s,
        input logic            comb_loss
    );
        logic [REG_W-1:0] w;
        w                    = '0;
        w[BIT_COMBINED_LOSS] = comb_loss;
        w[BIT_ANALOG_LOSS]   = s.analog_loss;
        w[BIT_DIGITAL_LOSS]  = s.digital_loss;
        w[BIT_DRIVE_MON]     = s.drive_monitor;
        status_word = w;
    endfunction : status_word

    // Write decode; reserved bits are masked except transmit control bit 0, and status is never written.
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            tx_nxt[c]  = tx_r[c];
            det_nxt[c] = det_r[c];
            out_nxt[c] = out_r[c];
            rl_nxt[c]  = rl_r[c];
            if (i_req.wr_en && (int'(addr_chan(i_req.addr)) == c))
            begin
                case (addr_idx(i_req.addr))
                    IDX_TX_CONTROL:
                        tx_nxt[c] = i_req.wdata & MASK_TX_CONTROL;
                    IDX_RX_DETECT_CTRL:
                        det_nxt[c] = i_req.wdata & MASK_RX_DETECT_CTRL;
                    IDX_RX_OUTPUT_CTRL:
                        out_nxt[c] = i_req.wdata & MASK_RX_OUTPUT_CTRL;
                    IDX_RATE_LOOP_SEL:
                        rl_nxt[c] = i_req.wdata & MASK_RATE_LOOP_SEL;
                    default: ;
                endcase
            end
        end
    end

    // Read mux: status is sampled live; unmapped addresses read zero.
    always_comb
    begin
        logic [1:0] ch;
        ch        = addr_chan(i_req.addr);
        rdata_nxt = '0;
        if (int'(ch) < CHANNELS)
        begin
            case (addr_idx(i_req.addr))
                IDX_ALARM_STATUS:
                    rdata_nxt = status_word(i_status[ch],
                                            o_combined_loss[ch]);
                IDX_TX_CONTROL:     rdata_nxt = tx_r[ch];
                IDX_RX_DETECT_CTRL: rdata_nxt = det_r[ch];
                IDX_RX_OUTPUT_CTRL: rdata_nxt = out_r[ch];
                IDX_RATE_LOOP_SEL:  rdata_nxt = rl_r[ch];
                default:            rdata_nxt = '0;
            endcase
        end
    end

    // Register update with synchronous active-low reset to all zeros.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                tx_r[c]  <= REG_RESET;
                det_r[c] <= REG_RESET;
                out_r[c] <= REG_RESET;
                rl_r[c]  <= REG_RESET;
            end
            rdata_r <= REG_RESET;
        end
        else
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                tx_r[c]  <= tx_nxt[c];
                det_r[c] <= det_nxt[c];
                out_r[c] <= out_nxt[c];
                rl_r[c]  <= rl_nxt[c];
            end
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // Per-channel decode, receive shaping and transmit line gating.
    for (genvar g = 0; g < CHANNELS; g++)
    begin : g_chan
        lucc_chan_decode u_dec (
            .i_tx_ctrl   (tx_r[g]),
            .i_rx_det    (det_r[g]),
            .i_rx_out    (out_r[g]),
            .i_rate_loop (rl_r[g]),
            .o_ctrl      (o_ctrl[g])
        );

        lucc_rx_path u_rx (
            .i_ctrl          (o_ctrl[g]),
            .i_status        (i_status[g]),
            .i_rx_pos        (i_rx_pos[g]),
            .i_rx_neg        (i_rx_neg[g]),
            .o_combined_loss (o_combined_loss[g]),
            .o_rx_pos        (o_rx_positive_data_out[g]),
            .o_rx_neg        (o_rx_negative_data_out[g])
        );

        // All-ones overrides terminal data; disable releases the line.
        always_comb
        begin
            o_tx_line_data[g] = o_ctrl[g].send_all_ones
                                || i_tx_positive_data_in[g];
            o_tx_line_oe[g]   = !o_ctrl[g].transmitter_disable;
        end
    end

endmodule : lucc_regs

// ==== rtl/lucc_rx_path.sv ====
// Receive output shaping for one channel: loss combining, rail format
// and muting. Assumes recovered rails arrive already decoded.
`timescale 1ns/1ps
module lucc_rx_path
    import lucc_pkg::*;
(
    input  lucc_pkg::lucc_ctrl_type   i_ctrl,
    input  lucc_pkg::lucc_status_type i_status,
    input  wire logic                 i_rx_pos,
    input  wire logic                 i_rx_neg,
    output logic                      o_combined_loss,
    output logic                      o_rx_pos,
    output logic                      o_rx_neg
);
    import lucc_pkg::*;

    // A disabled detector drops out of the combined loss indication.
    always_comb
    begin
        o_combined_loss = (i_ctrl.analog_detector_on && i_status.analog_loss)
            || (i_ctrl.digital_detector_on
                && i_status.digital_loss);
    end

    // Muting acts without the clock; single-rail grounds the negative rail.
    always_comb
    begin
        if (i_ctrl.receiver_shutdown
            || (i_ctrl.mute_on_signal_loss && o_combined_loss))
        begin
            o_rx_pos = 1'b0;
            o_rx_neg = 1'b0;
        end
        else
        begin
            o_rx_pos = i_rx_pos;
            o_rx_neg = i_ctrl.coder_enable ? 1'b0 : i_rx_neg;
        end
    end

endmodule : lucc_rx_path

// ==== verif/lucc_host.sv ====
// Host model: issues register requests, at most one per cycle.
// Assumes the bank samples the request on the rising clock edge.
`timescale 1ns/1ps
module lucc_host
    import lucc_pkg::*;
(
    input  wire logic                      i_clk_sys,
    input  wire logic [lucc_pkg::REG_W-1:0] i_rdata,
    output lucc_pkg::lucc_req_type         o_req
);
    import lucc_pkg::*;

    // Request starts idle on the channel 0 status address.
    initial o_req = '0;

    // A write pulse held across exactly one sampling edge.
    task automatic wr(input logic [4:0] a, input logic [4:0] d);
        @(posedge i_clk_sys);
        #1 o_req = '{wr_en: 1'b1, addr: a, wdata: d};
        @(posedge i_clk_sys);
        #1 o_req.wr_en = 1'b0;
    endtask : wr

    // Read data appears one edge after the address is taken.
    task automatic rd(input logic [4:0] a, output logic [4:0] d);
        @(posedge i_clk_sys);
        #1 o_req.addr = a;
        @(posedge i_clk_sys);
        #1 d = i_rdata;
    endtask : rd
endmodule : lucc_host

// ==== verif/lucc_regs_sva.sv ====
// Checker for the command register bank, bound to its ports.
// Assumes one clock domain; channel 0 stands for all three.
`timescale 1ns/1ps
module lucc_regs_sva
    import lucc_pkg::*;
#(
    parameter int unsigned CHANNELS = 3
)
(
    input wire logic                           i_clk_sys,
    input wire logic                           i_nrst,
    input lucc_pkg::lucc_req_type              i_req,
    input wire logic [lucc_pkg::REG_W-1:0]     o_rdata,
    input lucc_pkg::lucc_status_type [CHANNELS-1:0] i_status,
    input wire logic [CHANNELS-1:0]            i_tx_positive_data_in,
    input lucc_pkg::lucc_ctrl_type [CHANNELS-1:0] o_ctrl,
    input wire logic [CHANNELS-1:0]            o_combined_loss,
    input wire logic [CHANNELS-1:0]            o_rx_positive_data_out,
    input wire logic [CHANNELS-1:0]            o_rx_negative_data_out,
    input wire logic [CHANNELS-1:0]            o_tx_line_data,
    input wire logic [CHANNELS-1:0]            o_tx_line_oe
);
    import lucc_pkg::*;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    // A write request to one address.
    sequence s_wr(logic [4:0] a);
        i_req.wr_en && i_req.addr == a;
    endsequence

    // Writes land one cycle later; status reads follow the detectors.
    a_txoff_write: assert property (s_wr(5'h01) |=>
        o_tx_line_oe[0] == !$past(i_req.wdata[4])) else $error("tx oe");
    a_all_ones: assert property (1'b1 |-> o_tx_line_data[0] ==
        (o_ctrl[0].send_all_ones | i_tx_positive_data_in[0]))
        else $error("tx data");
    a_status_read: assert property (i_req.addr == 5'h00 |=>
        o_rdata[2:0] == $past(i_status[0])) else $error("status read");
    a_status_ro: assert property (s_wr(5'h00) |=> $stable(o_ctrl))
        else $error("status write");
    a_build_e3: assert property (o_ctrl[0].rate == LUCC_RATE_E3 |->
        !o_ctrl[0].build_out_bypass) else $error("build-out in E3");
    a_rate_write: assert property (s_wr(5'h04) |=> o_ctrl[0].rate ==
        ($past(i_req.wdata[2]) ? LUCC_RATE_E3 :
        ($past(i_req.wdata[3]) ? LUCC_RATE_STS1 : LUCC_RATE_DS3)))
        else $error("rate");
    a_loop_write: assert property (s_wr(5'h04) |=> o_ctrl[0].loop ==
        ($past(i_req.wdata[1]) ?
        ($past(i_req.wdata[0]) ? LUCC_LOOP_DIGITAL : LUCC_LOOP_ANALOG) :
        ($past(i_req.wdata[0]) ? LUCC_LOOP_REMOTE : LUCC_LOOP_NONE)))
        else $error("loopback");
    a_mute_loss: assert property (o_ctrl[0].mute_on_signal_loss &&
        o_combined_loss[0] |-> !o_rx_positive_data_out[0] &&
        !o_rx_negative_data_out[0]) else $error("mute");
    a_single_rail: assert property (o_ctrl[0].coder_enable |->
        !o_rx_negative_data_out[0]) else $error("single rail");
    a_coder_mode: assert property (o_ctrl[0].coder_enable |->
        o_ctrl[0].coder_hdb3 == (o_ctrl[0].rate == LUCC_RATE_E3))
        else $error("coder mode");
    a_loss_combine: assert property (1'b1 |-> o_combined_loss[0] ==
        (i_status[0].analog_loss & o_ctrl[0].analog_detector_on |
        i_status[0].digital_loss & o_ctrl[0].digital_detector_on))
        else $error("combined loss");
endmodule : lucc_regs_sva

bind lucc_regs lucc_regs_sva #(.CHANNELS(CHANNELS)) lucc_regs_sva_i (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(i_req),
    .o_rdata(o_rdata), .i_status(i_status),
    .i_tx_positive_data_in(i_tx_positive_data_in), .o_ctrl(o_ctrl),
    .o_combined_loss(o_combined_loss),
    .o_rx_positive_data_out(o_rx_positive_data_out),
    .o_rx_negative_data_out(o_rx_negative_data_out),
    .o_tx_line_data(o_tx_line_data), .o_tx_line_oe(o_tx_line_oe));

// ==== verif/testbench.sv ====
// Self-checking bench for the command register bank.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ps
module testbench;
    import lucc_pkg::*;
    localparam int CH = 3;
    logic                  i_clk_sys;
    logic                  i_nrst;
    lucc_req_type          req;
    logic [REG_W-1:0]      rdata;
    lucc_status_type [CH-1:0] st;
    logic [CH-1:0]         rxp;
    logic [CH-1:0]         rxn;
    logic [CH-1:0]         txd;
    lucc_ctrl_type [CH-1:0] ctrl;
    logic [CH-1:0]         closs;
    logic [CH-1:0]         rpos;
    logic [CH-1:0]         rneg;
    logic [CH-1:0]         tdat;
    logic [CH-1:0]         toe;
    int                    bad_count = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;
    logic [4:0] msk [5] = '{5'h00, MASK_TX_CONTROL, MASK_RX_DETECT_CTRL,
                            MASK_RX_OUTPUT_CTRL, MASK_RATE_LOOP_SEL};
    lucc_loop_type lp [4] = '{LUCC_LOOP_NONE, LUCC_LOOP_REMOTE,
                              LUCC_LOOP_ANALOG, LUCC_LOOP_DIGITAL};

    lucc_regs lucc_regs_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_req(req), .o_rdata(rdata), .i_status(st), .i_rx_pos(rxp),
        .i_rx_neg(rxn), .i_tx_positive_data_in(txd), .o_ctrl(ctrl),
        .o_combined_loss(closs), .o_rx_positive_data_out(rpos),
        .o_rx_negative_data_out(rneg), .o_tx_line_data(tdat),
        .o_tx_line_oe(toe));
    lucc_host lucc_host_i (.i_clk_sys(i_clk_sys), .i_rdata(rdata),
        .o_req(req));

    // 25 MHz system clock.
    initial
    begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    // Compares one value and counts the result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Reads one register and compares it.
    task automatic rc(input logic [4:0] a, input logic [4:0] e);
        logic [4:0] d;
        lucc_host_i.rd(a, d);
        chk(d, e);
    endtask : rc

    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // Cuts a hung run short.
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            final_report();
        end
    end

    // Main sequence.
    initial
    begin
        i_nrst = 1'b0;
        st = '0;
        rxp = '0;
        rxn = '0;
        txd = '0;
        repeat (10) @(posedge i_clk_sys);
        #1 i_nrst = 1'b1;
        for (int i = 0; i < 32; i++) rc(i[4:0], 5'h00);
        for (int a = 0; a < 24; a++)
        begin
            lucc_host_i.wr(a[4:0], 5'h1F);
            rc(a[4:0], (a % 8 < 5) ? msk[a % 8] : 5'h00);
            lucc_host_i.wr(a[4:0], 5'h00);
        end
        for (int p = 0; p < 8; p++)
        begin
            st[1] = p[2:0];
            rc(5'h08, {1'b0, p[2] | p[1], p[2:0]});
        end
        lucc_host_i.wr(5'h0A, 5'h04);
        st[1] = 3'b100;
        #1 chk(closs[1], 1'b0);
        @(posedge i_clk_sys);
        #1 st[1] = 3'b010;
        #1 chk(closs[1], 1'b1);
        lucc_host_i.wr(5'h0A, 5'h02);
        chk(closs[1], 1'b0);
        st[1] = 3'b100;
        #1 chk(closs[1], 1'b1);
        lucc_host_i.wr(5'h0A, 5'h00);
        st[1] = '0;
        lucc_host_i.wr(5'h01, 5'h10);
        chk(toe[0], 1'b0);
        lucc_host_i.wr(5'h01, 5'h08);
        chk({toe[0], tdat[0]}, 2'b11);
        lucc_host_i.wr(5'h01, 5'h00);
        chk(tdat[0], 1'b0);
        txd[0] = 1'b1;
        #1 chk(tdat[0], 1'b1);
        lucc_host_i.wr(5'h01, 5'h04);
        chk(ctrl[0].tx_sample_rising, 1'b1);
        lucc_host_i.wr(5'h01, 5'h02);
        chk(ctrl[0].build_out_bypass, 1'b1);
        lucc_host_i.wr(5'h04, 5'h04);
        chk(ctrl[0].build_out_bypass, 1'b0);
        lucc_host_i.wr(5'h02, 5'h01);
        chk(ctrl[0].equalizer_on, 1'b1);
        rxp[0] = 1'b1;
        rxn[0] = 1'b1;
        lucc_host_i.wr(5'h03, 5'h10);
        chk({rpos[0], rneg[0], ctrl[0].coder_hdb3}, 3'b101);
        lucc_host_i.wr(5'h04, 5'h00);
        chk(ctrl[0].coder_hdb3, 1'b0);
        lucc_host_i.wr(5'h03, 5'h08);
        chk({rpos[0], rneg[0]}, 2'b11);
        st[0] = 3'b100;
        #1 chk({rpos[0], rneg[0]}, 2'b00);
        rc(5'h00, 5'h0C);
        lucc_host_i.wr(5'h03, 5'h00);
        chk({rpos[0], rneg[0]}, 2'b11);
        st[0] = '0;
        lucc_host_i.wr(5'h03, 5'h04);
        chk(ctrl[0].receiver_shutdown, 1'b1);
        chk({rpos[0], rneg[0]}, 2'b00);
        lucc_host_i.wr(5'h03, 5'h02);
        chk(ctrl[0].rx_output_falling, 1'b1);
        for (int v = 0; v < 16; v++)
        begin
            lucc_host_i.wr(5'h04, v[4:0]);
            chk(ctrl[0].rate, v[2] ? LUCC_RATE_E3 :
                (v[3] ? LUCC_RATE_STS1 : LUCC_RATE_DS3));
            chk(ctrl[0].loop, lp[v[1:0]]);
        end
        final_report();
    end
endmodule : testbench
